// [ssie_status_irq.sv]
// Status flags, force-end control and interrupt enables of an SPI port.
// Assumes a shift engine on i_core_clk giving buffer and busy levels, and
// slave selects and serial clock arriving asynchronously from the link.
//
// Operation
// - Force-end bit ends the transfer after current transmitter activity, like end marker.
// - Hardware clears force-end bit when transmitter goes idle; resets to zero.
// - Forced end still gets the frame gap and deselect gap inserted.
// - Master idle flag is one when holding register empty and not shifting.
// - Enable set register: ones set bits, reads return enables, clear elsewhere.
// - Enable bit n gates status flag n in the same position.
// - Receive ready enable requests interrupt while received data waits.
// - Transmit ready enable requests interrupt while holding register accepts data.
// - Overrun enable requests interrupt when slave receive finds register occupied.
// - Master refuses to start a transmission that would overrun receive data.
// - Underrun enable requests interrupt when slave must transmit with no data.
// - Select assert enable requests interrupt when any select becomes asserted.
// - Select deassert enable requests interrupt when all asserted selects deassert.
// - Master idle enable requests interrupt while master fully idle; resets zero.
// - Writing one clears a clearable status flag; writing zero leaves it.
module ssie_status_irq (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_master,
    input wire logic i_rx_full,
    input wire logic i_rx_start,
    input wire logic i_tx_empty,
    input wire logic i_tx_busy,
    input wire logic i_stalled,
    input wire logic [3:0] i_sel_n,
    input wire logic i_sck,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output logic o_force_end,
    output logic o_start_ok,
    output logic o_master_idle
);

    // Two-stage synchronisers for the link pins
    ssie_pkg::ssie_link_t link_meta_q;
    ssie_pkg::ssie_link_t link_meta_d;
    ssie_pkg::ssie_link_t link_sync_q;
    ssie_pkg::ssie_link_t link_sync_d;
    ssie_pkg::ssie_link_t link_prev_q;
    ssie_pkg::ssie_link_t link_prev_d;

    // Register state
    logic [8:0] sticky_q;
    logic [8:0] sticky_d;
    logic force_end_q;
    logic force_end_d;
    logic master_idle_q;
    logic master_idle_d;
    logic [8:0] en_q;
    logic [8:0] en_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic irq_q;
    logic irq_d;
    logic start_ok_q;
    logic start_ok_d;

    // Decoded events and views
    logic [3:0] sel_act;
    logic [3:0] sel_prev_act;
    logic sck_rise;
    logic evt_sel_assert;
    logic evt_sel_deassert;
    logic evt_rx_overrun;
    logic evt_tx_underrun;
    logic wr_flags;
    logic wr_en_set;
    logic wr_en_clear;
    logic idle_now;
    logic [8:0] evt_vec;
    ssie_pkg::ssie_flags_t flags_now;

    // Clears bits written as one within a mask, events win over the clear
    function automatic logic [8:0] w1c_update(
        input logic [8:0] cur,
        input logic hit,
        input logic [31:0] wdata,
        input logic [8:0] mask,
        input logic [8:0] set_vec
    );
        logic [8:0] clr;
        clr = hit ? (wdata[8:0] & mask) : 9'h000;
        return (cur & ~clr) | set_vec;
    endfunction

    // Link pin synchroniser chain
    always_comb begin
        link_meta_d.sel_n = i_sel_n;
        link_meta_d.sck = i_sck;
        link_sync_d = link_meta_q;
        link_prev_d = link_sync_q;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            link_meta_q <= {ssie_pkg::SEL_N_RST, ssie_pkg::SCK_RST};
            link_sync_q <= {ssie_pkg::SEL_N_RST, ssie_pkg::SCK_RST};
            link_prev_q <= {ssie_pkg::SEL_N_RST, ssie_pkg::SCK_RST};
        end else begin
            link_meta_q <= link_meta_d;
            link_sync_q <= link_sync_d;
            link_prev_q <= link_prev_d;
        end
    end

    // Event detection, select and clock events only on synchronised samples
    always_comb begin
        sel_act = ~link_sync_q.sel_n;
        sel_prev_act = ~link_prev_q.sel_n;
        sck_rise = link_sync_q.sck & ~link_prev_q.sck;
        evt_sel_assert = |(sel_act & ~sel_prev_act);
        evt_sel_deassert = (|sel_prev_act) & ~(|sel_act);
        // Master mode never overruns, see start gating below
        evt_rx_overrun = ~i_master & i_rx_start & i_rx_full;
        // Slave must shift on this edge but nothing is loaded
        evt_tx_underrun = ~i_master & (|sel_act) & sck_rise & i_tx_empty
            & ~i_tx_busy;
        evt_vec = 9'h000;
        evt_vec[ssie_pkg::BIT_RX_OVERRUN] = evt_rx_overrun;
        evt_vec[ssie_pkg::BIT_TX_UNDERRUN] = evt_tx_underrun;
        evt_vec[ssie_pkg::BIT_SEL_ASSERT] = evt_sel_assert;
        evt_vec[ssie_pkg::BIT_SEL_DEASSERT] = evt_sel_deassert;
    end

    // Address decode
    always_comb begin
        wr_flags = 1'b0;
        wr_en_set = 1'b0;
        wr_en_clear = 1'b0;
        if (i_addr == ssie_pkg::ADDR_FLAGS_CTRL) begin
            wr_flags = i_wr;
        end else if (i_addr == ssie_pkg::ADDR_EN_SET) begin
            wr_en_set = i_wr;
        end else if (i_addr == ssie_pkg::ADDR_EN_CLEAR) begin
            wr_en_clear = i_wr;
        end
    end

    // Sticky flags, force-end and idle state
    always_comb begin
        idle_now = i_tx_empty & ~i_tx_busy;
        master_idle_d = idle_now;
        sticky_d = w1c_update(sticky_q, wr_flags, i_wdata, ssie_pkg::W1C_MASK,
            evt_vec);
        force_end_d = force_end_q;
        if (idle_now) begin
            force_end_d = 1'b0;
        end
        // Set wins so a write in an idle cycle is still seen once
        if (wr_flags && i_wdata[ssie_pkg::BIT_FORCE_END]) begin
            force_end_d = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sticky_q <= ssie_pkg::FLAGS_RST & ssie_pkg::W1C_MASK;
            force_end_q <= ssie_pkg::FLAGS_RST[ssie_pkg::BIT_FORCE_END];
            master_idle_q <= ssie_pkg::FLAGS_RST[ssie_pkg::BIT_MASTER_IDLE];
        end else begin
            sticky_q <= sticky_d;
            force_end_q <= force_end_d;
            master_idle_q <= master_idle_d;
        end
    end

    // Interrupt enables
    always_comb begin
        en_d = en_q;
        if (wr_en_set) begin
            en_d = en_q | (i_wdata[8:0] & ssie_pkg::EN_IMPL_MASK);
        end else begin
            en_d = w1c_update(en_q, wr_en_clear, i_wdata,
                ssie_pkg::EN_IMPL_MASK, 9'h000);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            en_q <= ssie_pkg::EN_RST;
        end else begin
            en_q <= en_d;
        end
    end

    // Live flag view, read back and interrupt
    always_comb begin
        flags_now.rx_ready = i_rx_full;
        flags_now.tx_ready = i_tx_empty;
        flags_now.rx_overrun = sticky_q[ssie_pkg::BIT_RX_OVERRUN];
        flags_now.tx_underrun = sticky_q[ssie_pkg::BIT_TX_UNDERRUN];
        flags_now.sel_assert = sticky_q[ssie_pkg::BIT_SEL_ASSERT];
        flags_now.sel_deassert = sticky_q[ssie_pkg::BIT_SEL_DEASSERT];
        flags_now.stalled = i_stalled;
        flags_now.force_end = force_end_q;
        flags_now.master_idle = master_idle_q;
        // Bit n of enables gates bit n of flags
        irq_d = |(flags_now & en_q & ssie_pkg::EN_IMPL_MASK);
        // Master holds off a new word while receive data is unread
        start_ok_d = ~(i_master & i_rx_full);
        rdata_d = ssie_pkg::RDATA_RST;
        if (i_rd) begin
            if (i_addr == ssie_pkg::ADDR_FLAGS_CTRL) begin
                rdata_d = {23'h000000, flags_now};
            end else if (i_addr == ssie_pkg::ADDR_EN_SET) begin
                rdata_d = {23'h000000, en_q};
            end else begin
                rdata_d = ssie_pkg::RDATA_RST;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rdata_q <= ssie_pkg::RDATA_RST;
            irq_q <= 1'b0;
            start_ok_q <= 1'b1;
        end else begin
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            start_ok_q <= start_ok_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_irq = irq_q;
    // Engine treats this as an end marker on the last word, gaps included
    assign o_force_end = force_end_q;
    assign o_start_ok = start_ok_q;
    assign o_master_idle = master_idle_q;

endmodule

// [ssie_pkg.sv]
// Package for the SPI status and interrupt-enable block: map, layout, resets.
// Assumes a 32-bit register port that carries full byte addresses.
package ssie_pkg;

    // Register byte addresses
    localparam logic [31:0] ADDR_FLAGS_CTRL = 32'h4005_8008;
    localparam logic [31:0] ADDR_EN_SET = 32'h4005_800C;
    localparam logic [31:0] ADDR_EN_CLEAR = 32'h4005_8010;

    // Field positions inside the flags register
    localparam int BIT_RX_READY = 0;
    localparam int BIT_TX_READY = 1;
    localparam int BIT_RX_OVERRUN = 2;
    localparam int BIT_TX_UNDERRUN = 3;
    localparam int BIT_SEL_ASSERT = 4;
    localparam int BIT_SEL_DEASSERT = 5;
    localparam int BIT_STALLED = 6;
    localparam int BIT_FORCE_END = 7;
    localparam int BIT_MASTER_IDLE = 8;

    localparam int FLAG_W = 9;
    localparam int SEL_W = 4;

    // Reset values
    localparam logic [8:0] FLAGS_RST = 9'h100;
    localparam logic [8:0] EN_RST = 9'h000;
    localparam logic [3:0] SEL_N_RST = 4'hF;
    localparam logic SCK_RST = 1'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // Implemented enable bits and write-one-to-clear flags
    localparam logic [8:0] EN_IMPL_MASK = 9'h13F;
    localparam logic [8:0] W1C_MASK = 9'h03C;

    // Flags and enables share one layout, bit 8 down to bit 0
    typedef struct packed {
        logic master_idle;
        logic force_end;
        logic stalled;
        logic sel_deassert;
        logic sel_assert;
        logic tx_underrun;
        logic rx_overrun;
        logic tx_ready;
        logic rx_ready;
    } ssie_flags_t;

    // Slave select pins and serial clock as sampled from the link
    typedef struct packed {
        logic [3:0] sel_n;
        logic sck;
    } ssie_link_t;

endpackage

// [ssie_status_irq_assertions.sv]
// Checker for the SPI status and interrupt-enable block.
// Assumes it is bound to ssie_status_irq and sees only its ports.
module ssie_status_irq_assertions (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_master,
    input wire logic i_rx_full,
    input wire logic i_tx_empty,
    input wire logic i_tx_busy,
    input wire logic [31:0] o_rdata,
    input wire logic o_irq,
    input wire logic o_force_end,
    input wire logic o_start_ok,
    input wire logic o_master_idle
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic fe_wr, idle, hold, rd_fl;
    assign fe_wr = i_wr && i_addr == ssie_pkg::ADDR_FLAGS_CTRL && i_wdata[7];
    assign idle = i_tx_empty && !i_tx_busy;
    assign hold = i_master && i_rx_full;
    assign rd_fl = i_rd && i_addr == ssie_pkg::ADDR_FLAGS_CTRL;
    AST_RDATA_ZERO: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside slot");
    AST_RSV_ZERO: assert property ($past(i_rd) |-> o_rdata[31:9] == 23'h0)
        else $error("reserved bits set");
    AST_START_GATE: assert property (!$past(i_rst) |-> o_start_ok == !$past(hold))
        else $error("start gate wrong");
    AST_FORCE_SET: assert property (fe_wr |=> o_force_end)
        else $error("force end not set");
    AST_FORCE_HOLD: assert property (o_force_end && !idle |=> o_force_end)
        else $error("force end dropped early");
    AST_FORCE_CLR: assert property (o_force_end && idle && !fe_wr |=> !o_force_end)
        else $error("force end not cleared");
    AST_IDLE_FLAG: assert property (!$past(i_rst) |-> o_master_idle == $past(idle))
        else $error("idle flag wrong");
    AST_IDLE_READ: assert property ($past(rd_fl) |->
        o_rdata[8:7] == {$past(o_master_idle), $past(o_force_end)})
        else $error("flag read wrong");
    AST_IRQ_OFF: assert property ((i_wr && i_addr == ssie_pkg::ADDR_EN_CLEAR
        && i_wdata[8:0] == 9'h1FF) ##1 !(i_wr && i_addr == ssie_pkg::ADDR_EN_SET)
        |=> !o_irq)
        else $error("irq with no enables");
endmodule
bind ssie_status_irq ssie_status_irq_assertions ssie_status_irq_assertions_inst (.*);

// [ssie_link_model.sv]
// Far-side SPI master model driving selects and serial clock.
// Assumes the bench calls frame(); the clock stands low between frames.
module ssie_link_model (
    output logic [3:0] o_sel_n,
    output logic o_sck
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_sel_n = 4'hF;
        o_sck = 1'h0;
    end
    // Odd lead-in keeps edges off the core clock phase
    task automatic frame(input int idx, input int bits);
        o_sel_n[idx] = 1'h0;
        #83;
        repeat (bits) begin
            o_sck = 1'h1;
            #80;
            o_sck = 1'h0;
            #80;
        end
        o_sel_n[idx] = 1'h1;
        #80;
    endtask
endmodule

// [testbench.sv]
// Self-checking bench for the SPI status and interrupt-enable block.
// Assumes the link model drives selects and serial clock asynchronously.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] a_fl = ssie_pkg::ADDR_FLAGS_CTRL;
    localparam logic [31:0] a_set = ssie_pkg::ADDR_EN_SET;
    localparam logic [31:0] a_clr = ssie_pkg::ADDR_EN_CLEAR;
    logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, master = 1'h0;
    logic rx_full = 1'h0, rx_start = 1'h0, tx_empty = 1'h1, tx_busy = 1'h0;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
    logic [3:0] sel_n;
    logic sck, irq, force_end, start_ok, master_idle;
    int failures = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    ssie_status_irq ssie_status_irq_inst (.i_core_clk(clk), .i_rst(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_master(master), .i_rx_full(rx_full),
        .i_rx_start(rx_start), .i_tx_empty(tx_empty), .i_tx_busy(tx_busy),
        .i_stalled(1'h0), .i_sel_n(sel_n), .i_sck(sck), .o_rdata(rdata), .o_irq(irq),
        .o_force_end(force_end), .o_start_ok(start_ok), .o_master_idle(master_idle));
    ssie_link_model ssie_link_model_inst (.o_sel_n(sel_n), .o_sck(sck));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rreg(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 chk(rdata, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic irq_try(input int b, input logic exp);
        wreg(a_set, 32'h1 << b);
        tick(3);
        chk(32'(irq), 32'(exp));
        wreg(a_clr, 32'h1 << b);
    endtask
    task automatic finish_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("unexpected at %0t: timeout", $time);
        finish_test;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        rreg(a_fl, 32'h102);
        rreg(a_set, 32'h0);
        rreg(32'h4005_8000, 32'h0);
        $display("test reset done");
        wreg(a_set, 32'h1);
        wreg(a_set, 32'h100);
        rreg(a_set, 32'h101);
        wreg(a_set, 32'h3E);
        rreg(a_set, 32'h13F);
        wreg(a_clr, 32'h1FF);
        rreg(a_set, 32'h0);
        $display("test enables done");
        @(posedge clk);
        tx_empty <= 1'h0;
        tx_busy <= 1'h1;
        irq_try(0, 1'h0);
        irq_try(1, 1'h0);
        irq_try(8, 1'h0);
        @(posedge clk);
        rx_full <= 1'h1;
        tx_empty <= 1'h1;
        tx_busy <= 1'h0;
        irq_try(0, 1'h1);
        irq_try(1, 1'h1);
        irq_try(8, 1'h1);
        $display("test live irq done");
        // Slave events: overrun pulse, then a framed select with clocks
        wreg(a_set, 32'h3C);
        @(posedge clk);
        rx_start <= 1'h1;
        @(posedge clk);
        rx_start <= 1'h0;
        ssie_link_model_inst.frame(2, 4);
        tick(6);
        rreg(a_fl, 32'h13F);
        chk(32'(irq), 32'h1);
        wreg(a_fl, 32'h3C);
        rreg(a_fl, 32'h103);
        chk(32'(irq), 32'h0);
        wreg(a_clr, 32'h1FF);
        $display("test link events done");
        @(posedge clk);
        master <= 1'h1;
        tx_empty <= 1'h0;
        tx_busy <= 1'h1;
        wreg(a_fl, 32'h80);
        tick(1);
        chk(32'(force_end), 32'h1);
        chk(32'(start_ok), 32'h0);
        chk(32'(master_idle), 32'h0);
        rreg(a_fl, 32'h81);
        @(posedge clk);
        tx_empty <= 1'h1;
        tx_busy <= 1'h0;
        tick(3);
        chk(32'(force_end), 32'h0);
        chk(32'(master_idle), 32'h1);
        wreg(a_fl, 32'h80);
        tick(3);
        chk(32'(force_end), 32'h0);
        $display("test force end done");
        finish_test;
    end
endmodule
